// File: rtl/pfsb_defs.svh
`ifndef PFSB_DEFS_SVH
`define PFSB_DEFS_SVH

// Command codes of the status bytes
`define PFSB_CMD_VOUT 8'h7A
`define PFSB_CMD_IOUT 8'h7B
`define PFSB_CMD_INPUT 8'h7C
`define PFSB_CMD_TEMP 8'h7D
`define PFSB_CMD_CML 8'h7E

// Output voltage byte fields
`define PFSB_VOUT_OV_BIT 7
`define PFSB_VOUT_UV_BIT 4
`define PFSB_VOUT_MAX_BIT 3
`define PFSB_VOUT_MASK 8'h98

// Output current byte fields
`define PFSB_IOUT_OC_BIT 7
`define PFSB_IOUT_OCUV_BIT 6
`define PFSB_IOUT_SHARE_BIT 3
`define PFSB_IOUT_MASK 8'hC8

// Input byte fields
`define PFSB_IN_OV_BIT 7
`define PFSB_IN_UV_BIT 4
`define PFSB_IN_OC_BIT 2
`define PFSB_IN_MASK 8'h94

// Temperature byte fields
`define PFSB_TEMP_OT_BIT 7
`define PFSB_TEMP_OTW_BIT 6
`define PFSB_TEMP_UT_BIT 4
`define PFSB_TEMP_MASK 8'hD0

// Communication, memory and logic byte fields
`define PFSB_CML_CMD_BIT 7
`define PFSB_CML_DATA_BIT 6
`define PFSB_CML_PEC_BIT 5
`define PFSB_CML_MEM_BIT 4
`define PFSB_CML_CPU_BIT 3
`define PFSB_CML_COMM_BIT 1
`define PFSB_CML_OTHER_BIT 0
`define PFSB_CML_MASK 8'hFB

// Reset value of every status byte
`define PFSB_FLAGS_RESET 8'h00

`endif

// File: rtl/pfsb_pkg.sv
`default_nettype none
package pfsb_pkg;
    // One status byte
    typedef logic [7:0] pfsb_byte_t;
    // Which status byte a command code selects
    typedef enum logic [2:0] {
        PFSB_SEL_NONE,
        PFSB_SEL_VOUT,
        PFSB_SEL_IOUT,
        PFSB_SEL_INPUT,
        PFSB_SEL_TEMP,
        PFSB_SEL_CML
    } pfsb_sel_t;
endpackage : pfsb_pkg
`default_nettype wire

// File: rtl/pfsb_flag_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfsb_defs.svh"
module pfsb_flag_latch
    import pfsb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] USED_MASK = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Events and clear
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clear,
    // Latched flags
    output logic [WIDTH-1:0] o_flags
);
    // Flag state and its next value
    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // Set beats clear; unused positions never rise
            always_comb begin
                flag_next[g] = USED_MASK[g] & (i_set[g] | (flag_reg[g] & ~i_clear));
            end
        end
    endgenerate

    // Register the flags
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_reg <= WIDTH'(`PFSB_FLAGS_RESET);
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flags = flag_reg;

    a_set_beats_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (|(i_set & USED_MASK)) |=> ((o_flags & $past(i_set & USED_MASK)) == $past(i_set & USED_MASK)))
        else $error("flag event lost");
    a_unused_stay_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ##1 ((o_flags & ~USED_MASK) == '0))
        else $error("unused flag bit set");
endmodule : pfsb_flag_latch
`default_nettype wire

// File: rtl/pfsb_uv_arm.sv
`timescale 1ns/10ps
`default_nettype none
module pfsb_uv_arm
    import pfsb_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Input voltage comparator level and raw fault
    input wire logic i_vin_above_uv,
    input wire logic i_uv_fault,
    // Gated fault and arm state
    output logic o_uv_set,
    output logic o_armed
);
    // Arm state: high once the input has been above the threshold
    logic armed_reg;
    logic armed_next;

    // Arm on the first rise, stay armed until reset
    always_comb begin
        armed_next = armed_reg | i_vin_above_uv;
    end

    // Register the arm state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end

    // Fault passes only once armed
    assign o_uv_set = i_uv_fault & armed_reg;
    assign o_armed = armed_reg;

    a_uv_blocked: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_uv_fault && !$past(i_vin_above_uv) && !$past(armed_reg)) |-> !o_uv_set)
        else $error("undervoltage passed before arming");
    a_arm_latency: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_vin_above_uv |=> (o_armed [*3]))
        else $error("arm did not follow input rise");
endmodule : pfsb_uv_arm
`default_nettype wire

// File: rtl/pfsb_status_bank.sv
// Operation
// - Paged output voltage byte at 7Ah
// - Voltage byte bit 7: overvoltage fault
// - Voltage byte bit 4: undervoltage fault
// - Voltage byte bit 3: maximum voltage warning
// - Paged output current byte at 7Bh
// - Current byte bit 7: overcurrent fault
// - Current byte bit 6: overcurrent with undervoltage
// - Current byte bit 3: phase share fault
// - Global input byte at 7Ch
// - Input byte bit 7: input overvoltage
// - Input bit 4 undervoltage, masked until armed
// - Input byte bit 2: input overcurrent
// - Global temperature byte at 7Dh
// - Temperature bits 7, 6, 4 faults/warning
// - Global comm/memory/logic byte at 7Eh
// - Bit 7: invalid or unsupported command
// - Bit 6: invalid or unsupported data
// - Bit 5: packet error check failure
// - Bit 1: other communication fault
// - Bits 4, 3, 0: memory, processor, other
// - Any voltage flag drives word bit 15
// - Any comm/memory/logic flag drives summary bit 1
`timescale 1ns/10ps
`default_nettype none
`include "pfsb_defs.svh"
module pfsb_status_bank
    import pfsb_pkg::*;
#(
    parameter int NUM_PAGES = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Status read port from the bus slave
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_cmd,
    input wire logic [7:0] i_page,
    output logic o_rd_valid,
    output logic o_rd_hit,
    output logic [7:0] o_rd_data,
    // Host clear of all latched faults
    input wire logic i_clear_faults,
    // Per-page output voltage events
    input wire logic [NUM_PAGES-1:0] i_vout_ov,
    input wire logic [NUM_PAGES-1:0] i_vout_uv,
    input wire logic [NUM_PAGES-1:0] i_vout_max,
    // Per-page output current events
    input wire logic [NUM_PAGES-1:0] i_iout_oc,
    input wire logic [NUM_PAGES-1:0] i_iout_ocuv,
    input wire logic [NUM_PAGES-1:0] i_iout_share,
    // Input supply events
    input wire logic i_vin_ov,
    input wire logic i_vin_uv,
    input wire logic i_vin_above_uv,
    input wire logic i_iin_oc,
    // Temperature events
    input wire logic i_ot_fault,
    input wire logic i_ot_warn,
    input wire logic i_ut_fault,
    // Communication, memory and logic events
    input wire logic i_bad_cmd,
    input wire logic i_bad_data,
    input wire logic i_pec_err,
    input wire logic i_mem_fault,
    input wire logic i_cpu_fault,
    input wire logic i_comm_other,
    input wire logic i_logic_other,
    // Summary indications
    output logic o_sum_vout,
    output logic o_sum_cml
);
    // Set vectors per byte
    pfsb_byte_t vout_set [NUM_PAGES];
    pfsb_byte_t iout_set [NUM_PAGES];
    pfsb_byte_t input_set;
    pfsb_byte_t temp_set;
    pfsb_byte_t cml_set;
    // Latched flag bytes
    pfsb_byte_t output_voltage_fault_flags [NUM_PAGES];
    pfsb_byte_t output_current_fault_flags [NUM_PAGES];
    pfsb_byte_t input_supply_fault_flags;
    pfsb_byte_t thermal_fault_flags;
    pfsb_byte_t comm_memory_logic_error_flags;
    // Gated input undervoltage event
    logic vin_uv_gated;
    // Page-selected paged bytes
    pfsb_byte_t vout_page_byte;
    pfsb_byte_t iout_page_byte;
    // Read decode
    pfsb_sel_t rd_sel;
    pfsb_byte_t rd_mux;
    logic rd_known;
    // Read answer state
    logic rd_valid_reg;
    logic rd_valid_next;
    logic rd_hit_reg;
    logic rd_hit_next;
    pfsb_byte_t rd_data_reg;
    pfsb_byte_t rd_data_next;
    // Summary state
    logic sum_vout_reg;
    logic sum_vout_next;
    logic sum_cml_reg;
    logic sum_cml_next;

    genvar p;
    generate
        for (p = 0; p < NUM_PAGES; p++) begin : g_page
            // Pack this page's voltage and current events
            always_comb begin
                vout_set[p] = 8'h00;
                vout_set[p][`PFSB_VOUT_OV_BIT] = i_vout_ov[p];
                vout_set[p][`PFSB_VOUT_UV_BIT] = i_vout_uv[p];
                vout_set[p][`PFSB_VOUT_MAX_BIT] = i_vout_max[p];
                iout_set[p] = 8'h00;
                iout_set[p][`PFSB_IOUT_OC_BIT] = i_iout_oc[p];
                iout_set[p][`PFSB_IOUT_OCUV_BIT] = i_iout_ocuv[p];
                iout_set[p][`PFSB_IOUT_SHARE_BIT] = i_iout_share[p];
            end
            // Voltage byte of this page
            pfsb_flag_latch #(
                .WIDTH(8),
                .USED_MASK(`PFSB_VOUT_MASK)
            ) u_vout (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_set(vout_set[p]),
                .i_clear(i_clear_faults),
                .o_flags(output_voltage_fault_flags[p])
            );
            // Current byte of this page
            pfsb_flag_latch #(
                .WIDTH(8),
                .USED_MASK(`PFSB_IOUT_MASK)
            ) u_iout (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_set(iout_set[p]),
                .i_clear(i_clear_faults),
                .o_flags(output_current_fault_flags[p])
            );
        end
    endgenerate

    // Undervoltage mask until the input first rises
    pfsb_uv_arm u_uv_arm (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_vin_above_uv(i_vin_above_uv),
        .i_uv_fault(i_vin_uv),
        .o_uv_set(vin_uv_gated),
        .o_armed()
    );

    // Pack the global events
    always_comb begin
        input_set = 8'h00;
        input_set[`PFSB_IN_OV_BIT] = i_vin_ov;
        input_set[`PFSB_IN_UV_BIT] = vin_uv_gated;
        input_set[`PFSB_IN_OC_BIT] = i_iin_oc;
        temp_set = 8'h00;
        temp_set[`PFSB_TEMP_OT_BIT] = i_ot_fault;
        temp_set[`PFSB_TEMP_OTW_BIT] = i_ot_warn;
        temp_set[`PFSB_TEMP_UT_BIT] = i_ut_fault;
        cml_set = 8'h00;
        cml_set[`PFSB_CML_CMD_BIT] = i_bad_cmd;
        cml_set[`PFSB_CML_DATA_BIT] = i_bad_data;
        cml_set[`PFSB_CML_PEC_BIT] = i_pec_err;
        cml_set[`PFSB_CML_COMM_BIT] = i_comm_other;
        cml_set[`PFSB_CML_MEM_BIT] = i_mem_fault;
        cml_set[`PFSB_CML_CPU_BIT] = i_cpu_fault;
        cml_set[`PFSB_CML_OTHER_BIT] = i_logic_other;
    end

    // Global input byte
    pfsb_flag_latch #(
        .WIDTH(8),
        .USED_MASK(`PFSB_IN_MASK)
    ) u_input (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_set(input_set),
        .i_clear(i_clear_faults),
        .o_flags(input_supply_fault_flags)
    );

    // Global temperature byte
    pfsb_flag_latch #(
        .WIDTH(8),
        .USED_MASK(`PFSB_TEMP_MASK)
    ) u_temp (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_set(temp_set),
        .i_clear(i_clear_faults),
        .o_flags(thermal_fault_flags)
    );

    // Global comm, memory and logic byte
    pfsb_flag_latch #(
        .WIDTH(8),
        .USED_MASK(`PFSB_CML_MASK)
    ) u_cml (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_set(cml_set),
        .i_clear(i_clear_faults),
        .o_flags(comm_memory_logic_error_flags)
    );

    // Pick the paged bytes of the selected page; unknown pages read zero
    always_comb begin
        vout_page_byte = 8'h00;
        iout_page_byte = 8'h00;
        for (int k = 0; k < NUM_PAGES; k++) begin
            // Matching page drives the paged bytes
            if (i_page == 8'(k)) begin
                vout_page_byte = output_voltage_fault_flags[k];
                iout_page_byte = output_current_fault_flags[k];
            end
        end
    end

    // Decode the command code
    always_comb begin
        rd_sel = PFSB_SEL_NONE;
        if (i_rd_cmd == `PFSB_CMD_VOUT) begin
            rd_sel = PFSB_SEL_VOUT;
        end else if (i_rd_cmd == `PFSB_CMD_IOUT) begin
            rd_sel = PFSB_SEL_IOUT;
        end else if (i_rd_cmd == `PFSB_CMD_INPUT) begin
            rd_sel = PFSB_SEL_INPUT;
        end else if (i_rd_cmd == `PFSB_CMD_TEMP) begin
            rd_sel = PFSB_SEL_TEMP;
        end else if (i_rd_cmd == `PFSB_CMD_CML) begin
            rd_sel = PFSB_SEL_CML;
        end
    end

    // Read data multiplexer
    always_comb begin
        rd_known = 1'b1;
        case (rd_sel)
            PFSB_SEL_VOUT: rd_mux = vout_page_byte;
            PFSB_SEL_IOUT: rd_mux = iout_page_byte;
            PFSB_SEL_INPUT: rd_mux = input_supply_fault_flags;
            PFSB_SEL_TEMP: rd_mux = thermal_fault_flags;
            PFSB_SEL_CML: rd_mux = comm_memory_logic_error_flags;
            default: begin
                // Not one of ours: zero, no hit
                rd_mux = 8'h00;
                rd_known = 1'b0;
            end
        endcase
    end

    // Next read answer; a read never touches the flags
    always_comb begin
        rd_valid_next = i_rd_req;
        rd_hit_next = rd_hit_reg;
        rd_data_next = rd_data_reg;
        if (i_rd_req) begin
            rd_hit_next = rd_known;
            rd_data_next = rd_mux;
        end
    end

    // Next summary bits
    always_comb begin
        sum_vout_next = 1'b0;
        for (int k = 0; k < NUM_PAGES; k++) begin
            // Either page raises the voltage summary
            sum_vout_next = sum_vout_next | (|output_voltage_fault_flags[k]);
        end
        sum_cml_next = |comm_memory_logic_error_flags;
    end

    // Register the read answer and summaries
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_valid_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
            rd_data_reg <= `PFSB_FLAGS_RESET;
            sum_vout_reg <= 1'b0;
            sum_cml_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_hit_reg <= rd_hit_next;
            rd_data_reg <= rd_data_next;
            sum_vout_reg <= sum_vout_next;
            sum_cml_reg <= sum_cml_next;
        end
    end

    // Drive the outputs
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_hit = rd_hit_reg;
    assign o_rd_data = rd_data_reg;
    assign o_sum_vout = sum_vout_reg;
    assign o_sum_cml = sum_cml_reg;

    a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_rd_req |=> o_rd_valid ##1 (!o_rd_valid || $past(i_rd_req)))
        else $error("read answer timing wrong");
    a_page_select: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd_req && i_rd_cmd == `PFSB_CMD_VOUT && i_page == 8'h00)
        |=> (o_rd_data == $past(output_voltage_fault_flags[0])))
        else $error("voltage byte not from page 0");
    a_last_page: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd_req && i_rd_cmd == `PFSB_CMD_IOUT && i_page == 8'(NUM_PAGES - 1))
        |=> (o_rd_data == $past(output_current_fault_flags[NUM_PAGES-1])))
        else $error("current byte not from last page");
    a_vout_ov_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_vout_ov[0] ##1 !i_clear_faults [*2]) |=> output_voltage_fault_flags[0][`PFSB_VOUT_OV_BIT])
        else $error("overvoltage flag not held");
    a_pec_over_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_pec_err && i_clear_faults) |=> comm_memory_logic_error_flags[`PFSB_CML_PEC_BIT])
        else $error("packet error lost on clear");
    a_temp_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_clear_faults && !i_ot_fault && !i_ot_warn && !i_ut_fault) |=> (thermal_fault_flags == 8'h00))
        else $error("temperature byte not cleared");
    a_unknown_cmd: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd_req && i_rd_cmd == 8'h7F) |=> (!o_rd_hit && o_rd_data == 8'h00))
        else $error("unknown command answered");
    a_input_unused: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd_req && i_rd_cmd == `PFSB_CMD_INPUT) |=> ((o_rd_data & ~`PFSB_IN_MASK) == 8'h00))
        else $error("unused input bits read high");
    a_sum_vout: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(output_voltage_fault_flags[0][`PFSB_VOUT_UV_BIT]) |=> o_sum_vout)
        else $error("voltage summary missing");
    a_sum_cml: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (comm_memory_logic_error_flags == 8'h00) |=> !o_sum_cml)
        else $error("cml summary stuck high");
endmodule : pfsb_status_bank
`default_nettype wire

// File: testbench/pfsb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfsb_defs.svh"
module pfsb_host_model (
    // Clock
    input wire logic i_clk,
    // Read request toward the bank
    output logic o_rd_req,
    output logic [7:0] o_rd_cmd,
    output logic [7:0] o_page,
    // Answer from the bank
    input wire logic i_rd_valid,
    input wire logic i_rd_hit,
    input wire logic [7:0] i_rd_data
);
    // Request lines start idle
    initial begin
        o_rd_req = 1'b0;
        o_rd_cmd = 8'h00;
        o_page = 8'h00;
    end

    // Released lines show the inverse of their last value, so stale codes are never seen
    task automatic release_bus();
        o_rd_req = 1'b0;
        o_rd_cmd = ~o_rd_cmd;
        o_page = ~o_page;
    endtask : release_bus

    // Single read: answer sampled once the taking edge has settled, then one idle cycle
    task automatic read_one(input logic [7:0] cmd, input logic [7:0] page, output logic [9:0] ans);
        o_rd_req = 1'b1;
        o_rd_cmd = cmd;
        o_page = page;
        @(posedge i_clk);
        #1;
        ans = {i_rd_valid, i_rd_hit, i_rd_data};
        release_bus();
        @(posedge i_clk);
        #1;
    endtask : read_one

    // Back to back reads of all seven bytes: both voltage pages, both current pages, then globals
    task automatic read_all(input logic [7:0] page_g, output logic [69:0] ans);
        o_rd_req = 1'b1;
        for (int k = 0; k < 7; k++) begin
            o_rd_cmd = (k < 4) ? `PFSB_CMD_VOUT + 8'(k / 2) : `PFSB_CMD_VOUT + 8'(k - 2);
            o_page = (k < 4) ? 8'(k % 2) : page_g;
            @(posedge i_clk);
            #1;
            ans[k*10 +: 10] = {i_rd_valid, i_rd_hit, i_rd_data};
        end
        release_bus();
        @(posedge i_clk);
        #1;
    endtask : read_all
endmodule : pfsb_host_model
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pfsb_pkg::*;
    // Clock, reset and controls
    logic i_clk, i_rstn, i_clear_faults, i_vin_above_uv;
    // All 25 event inputs packed together
    logic [24:0] ev;
    // Read port and summaries
    logic rd_req, rd_valid, rd_hit, sum_vout, sum_cml;
    logic [7:0] rd_cmd, rd_page, rd_data;
    // Counters and expectation model
    int n_errors, n_checks;
    logic [7:0] exp_b [7];
    logic armed;
    logic [31:0] rnd;
    logic [69:0] ans;
    logic [9:0] one;

    pfsb_status_bank #(.NUM_PAGES(2)) pfsb_status_bank_i (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_rd_req(rd_req), .i_rd_cmd(rd_cmd), .i_page(rd_page),
        .o_rd_valid(rd_valid), .o_rd_hit(rd_hit), .o_rd_data(rd_data), .i_clear_faults(i_clear_faults),
        .i_vout_ov(ev[1:0]), .i_vout_uv(ev[3:2]), .i_vout_max(ev[5:4]),
        .i_iout_oc(ev[7:6]), .i_iout_ocuv(ev[9:8]), .i_iout_share(ev[11:10]),
        .i_vin_ov(ev[12]), .i_vin_uv(ev[13]), .i_vin_above_uv(i_vin_above_uv), .i_iin_oc(ev[14]),
        .i_ot_fault(ev[15]), .i_ot_warn(ev[16]), .i_ut_fault(ev[17]),
        .i_bad_cmd(ev[18]), .i_bad_data(ev[19]), .i_pec_err(ev[20]), .i_mem_fault(ev[21]),
        .i_cpu_fault(ev[22]), .i_comm_other(ev[23]), .i_logic_other(ev[24]),
        .o_sum_vout(sum_vout), .o_sum_cml(sum_cml));

    pfsb_host_model pfsb_host_model_i (
        .i_clk(i_clk), .o_rd_req(rd_req), .o_rd_cmd(rd_cmd), .o_page(rd_page),
        .i_rd_valid(rd_valid), .i_rd_hit(rd_hit), .i_rd_data(rd_data));

    // 40 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Byte k (0/1 voltage pages, 2/3 current pages, 4 input, 5 temperature, 6 comm) set by events e
    function automatic logic [7:0] byte_of(input logic [24:0] e, input int k, input logic arm);
        case (k)
            0, 1: byte_of = {e[k], 2'b00, e[2+k], e[4+k], 3'b000};
            2, 3: byte_of = {e[4+k], e[6+k], 2'b00, e[8+k], 3'b000};
            4: byte_of = {e[12], 2'b00, e[13] & arm, 1'b0, e[14], 2'b00};
            5: byte_of = {e[15], e[16], 1'b0, e[17], 4'h0};
            default: byte_of = {e[18], e[19], e[20], e[21], e[22], 1'b0, e[23], e[24]};
        endcase
    endfunction : byte_of

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] expv);
        n_checks++;
        if (seen !== expv) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check

    // Verdict and end of run
    task automatic complete_run();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Reset for five cycles; the arming level is dropped so the mask starts closed again
    task automatic do_reset();
        i_rstn = 1'b0;
        i_vin_above_uv = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        armed = 1'b0;
        for (int k = 0; k < 7; k++) exp_b[k] = 8'h00;
    endtask : do_reset

    // One cycle of events, optional clear in the same cycle (set wins), then an idle cycle
    task automatic apply(input logic [24:0] e, input logic clr, input logic above);
        ev = e;
        i_clear_faults = clr;
        i_vin_above_uv = above;
        @(posedge i_clk);
        #1;
        for (int k = 0; k < 7; k++) exp_b[k] = clr ? byte_of(e, k, armed) : exp_b[k] | byte_of(e, k, armed);
        armed = armed | above;
        ev = '0;
        i_clear_faults = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : apply

    // Read every byte back to back and compare, then the summaries
    task automatic check_all(input logic [7:0] page_g);
        pfsb_host_model_i.read_all(page_g, ans);
        for (int k = 0; k < 7; k++) begin
            check(ans[k*10 +: 10], {2'b11, exp_b[k]});
        end
        check({sum_vout, sum_cml}, {|(exp_b[0] | exp_b[1]), |exp_b[6]});
    endtask : check_all

    // Hang guard
    initial begin
        repeat (30000) @(posedge i_clk);
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        n_checks = 0;
        ev = '0;
        i_clear_faults = 1'b0;
        rnd = 32'h7E01;
        do_reset();
        check_all(8'h00);
        // Undervoltage stays masked before arming and in the arming cycle itself
        apply(25'(1) << 13, 1'b0, 1'b0);
        check_all(8'h00);
        apply(25'(1) << 13, 1'b0, 1'b1);
        check_all(8'h01);
        apply(25'(1) << 13, 1'b0, 1'b1);
        check_all(8'h01);
        // Every event alone, clearing the previous ones in the same cycle
        for (int b = 0; b < 25; b++) begin
            apply(25'(1) << b, 1'b1, 1'b1);
            check_all(8'(b));
        end
        // Everything at once, then a plain clear; reading twice leaves flags alone
        apply('1, 1'b0, 1'b1);
        check_all(8'hFF);
        check_all(8'h7E);
        apply('0, 1'b1, 1'b1);
        check_all(8'h00);
        // Random events with occasional clears
        repeat (40) begin
            rnd = lfsr(rnd);
            apply(rnd[24:0], rnd[31:29] == 3'b000, 1'b1);
            check_all(rnd[7:0]);
        end
        // Unknown codes read as a miss with zero data, valid for one cycle only
        apply('1, 1'b0, 1'b1);
        for (int j = 0; j < 5; j++) begin
            rnd = lfsr(rnd);
            pfsb_host_model_i.read_one((j == 0) ? 8'h79 : (j == 1) ? 8'h7F : rnd[7:0] | 8'h80, 8'h00, one);
            check(one, 10'h200);
            check(rd_valid, 1'b0);
        end
        // Pages beyond the second read zero on paged bytes
        pfsb_host_model_i.read_one(8'h7A, 8'h02, one);
        check(one, 10'h300);
        pfsb_host_model_i.read_one(8'h7B, rnd[15:8] | 8'h02, one);
        check(one, 10'h300);
        // Reset in mid-run clears flags and closes the undervoltage mask again
        do_reset();
        check_all(8'h00);
        apply(25'(1) << 13, 1'b0, 1'b0);
        check_all(8'h00);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
